/* hw/bus_seq_pkg.sv */
// Purpose: Shared constants and types for the CPU bus-cycle sequencer
// Assumes: One ref_clk cycle per CPU bus cycle
// Notes:   Bus offsets, stack counts and codes live here; the vector and stack byte indices are literals in the design
package bus_seq_pkg;

    // Fixed bus addresses
    localparam logic [15:0] VEC_DUMMY       = 16'hffff;
    localparam logic [15:0] VEC_TRAP_HI     = 16'hfffa;
    localparam logic [15:0] VEC_TRAP_LO     = 16'hfffb;

    // Value returned by any read of a write-only register
    localparam logic [7:0]  WO_READ         = 8'hff;

    // Instruction kinds presented with op_start
    localparam logic [2:0]  OP_IDLE_IRQ     = 3'h0;
    localparam logic [2:0]  OP_RETURN       = 3'h1;
    localparam logic [2:0]  OP_TRAP         = 3'h2;
    localparam logic [2:0]  OP_BRANCH       = 3'h3;
    localparam logic [2:0]  OP_BSR          = 3'h4;

    // Stack byte counts, as last index
    localparam logic [2:0]  STACK_LAST      = 3'h6;
    localparam logic [2:0]  BSR_LAST        = 3'h1;

    // Address and stack pointer deltas
    localparam logic [15:0] ONE_BYTE        = 16'h0001;
    localparam logic [15:0] TWO_BYTES       = 16'h0002;
    localparam logic [15:0] STACK_DELTA     = 16'h0007;

    // Reset values
    localparam logic [15:0] ADDR_RST        = 16'hffff;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [15:0] WORD_RST        = 16'h0000;

    // Sequencer states, one-hot
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_FETCH = 8'h02,
        S_DUMMY = 8'h04,
        S_PUSH  = 8'h08,
        S_PULL  = 8'h10,
        S_WAIT  = 8'h20,
        S_VEC   = 8'h40,
        S_LAST  = 8'h80
    } seq_state_t;

endpackage

/* hw/clear_sync.sv */
// Purpose: Brings the power-on clear pin into the ref_clk domain
// Assumes: Pin is active low and asynchronous to ref_clk
// Notes:   Output stays low until two edges see the pin released
`timescale 1ns/100ps
module clear_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Pin and result
    input  wire logic power_on_clear_input_n,
    output logic      run_ok
);
    logic meta_r;
    logic meta_nxt;
    logic run_nxt;

    always_comb begin
        meta_nxt = power_on_clear_input_n;
        run_nxt  = meta_r;
    end

    // Sampled on the clock, so nothing takes effect before the clock runs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            run_ok <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            run_ok <= run_nxt;
        end
    end

endmodule

/* hw/bus_cycle_seq.sv */
// Purpose: Sequences bus cycles for interrupt wait, return, trap and branches
// Assumes: Core pulses op_start in idle with kind, opcode address and registers
// Notes:   Memory answers din in the same cycle the address is presented
// Functional notes
// - Interrupt wait fetches, does a dummy at ffff, pushes seven bytes, then waits.
// - Return reads seven bytes from sp+1 to sp+7 then fetches at the return address.
// - Trap pushes seven bytes, reads its vector at fffa and fffb, then fetches there.
// - Cycle two is a dummy at ffff with both strobes off; strobes follow direction.
// - A conditional branch takes three cycles ending at the target or the next opcode.
// - Branch to subroutine pushes return low at sp and high at sp-1 in five cycles.
// - A read of a write-only register yields ff whatever is stored.
// - The clear pin is sampled on the internal clock before it acts.
`timescale 1ns/100ps
module bus_cycle_seq (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        power_on_clear_input_n,
    // Instruction request
    input  wire logic        op_start,
    input  wire logic [2:0]  op_kind,
    input  wire logic [15:0] op_addr,
    input  wire logic        branch_test,
    input  wire logic [15:0] sp_in,
    input  wire logic [15:0] x_in,
    input  wire logic [7:0]  a_in,
    input  wire logic [7:0]  b_in,
    input  wire logic [7:0]  ccr_in,
    input  wire logic        irq_pending,
    input  wire logic [15:0] irq_vector,
    output logic             busy,
    // External bus
    output logic [15:0]      addr_r,
    output logic             rw_r,
    output logic             rd_n_r,
    output logic             wr_n_r,
    output logic [7:0]       dout_r,
    input  wire logic [7:0]  din,
    input  wire logic        wo_hit,
    // Results
    output logic             done_r,
    output logic [15:0]      pc_out_r,
    output logic [15:0]      sp_out_r,
    output logic [15:0]      x_out_r,
    output logic [7:0]       a_out_r,
    output logic [7:0]       b_out_r,
    output logic [7:0]       ccr_out_r
);
    bus_seq_pkg::seq_state_t st_r, st_nxt;
    logic [2:0]  idx_r, idx_nxt;
    logic [2:0]  kind_r, kind_nxt;
    logic        test_r, test_nxt;
    logic [15:0] opa_r, opa_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [15:0] x_r, x_nxt;
    logic [7:0]  a_r, a_nxt;
    logic [7:0]  b_r, b_nxt;
    logic [7:0]  ccr_r, ccr_nxt;
    logic [15:0] vbase_r, vbase_nxt;
    logic [7:0]  off_r, off_nxt;
    logic [7:0]  vhi_r, vhi_nxt;
    logic [7:0]  rhi_r, rhi_nxt;
    logic [15:0] addr_nxt;
    logic        rw_nxt;
    logic        rd_n_nxt;
    logic        wr_n_nxt;
    logic [7:0]  dout_nxt;
    logic        done_nxt;
    logic [15:0] pc_out_nxt;
    logic [15:0] sp_out_nxt;
    logic [15:0] x_out_nxt;
    logic [7:0]  a_out_nxt;
    logic [7:0]  b_out_nxt;
    logic [7:0]  ccr_out_nxt;
    logic        run_ok;
    logic [7:0]  rd_val;
    logic [15:0] ret_addr;
    logic [15:0] br_tgt;

    clear_sync u_clear_sync (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .power_on_clear_input_n (power_on_clear_input_n),
        .run_ok                 (run_ok)
    );

    assign rd_val   = wo_hit ? bus_seq_pkg::WO_READ : din;
    assign busy     = (st_r != bus_seq_pkg::S_IDLE);
    assign br_tgt   = 16'(opa_r + bus_seq_pkg::TWO_BYTES + {{8{off_r[7]}}, off_r});
    assign ret_addr = (kind_r == bus_seq_pkg::OP_BSR) ?
                      16'(opa_r + bus_seq_pkg::TWO_BYTES) :
                      16'(opa_r + bus_seq_pkg::ONE_BYTE);

    function automatic logic [7:0] push_sel(input logic [2:0] i, input logic [15:0] ra,
                                            input logic [15:0] xv, input logic [7:0] av,
                                            input logic [7:0] bv, input logic [7:0] cv);
        logic [7:0] v;
        v = cv;
        case (i)
            3'h0:    v = ra[7:0];
            3'h1:    v = ra[15:8];
            3'h2:    v = xv[7:0];
            3'h3:    v = xv[15:8];
            3'h4:    v = av;
            3'h5:    v = bv;
            default: v = cv;
        endcase
        return v;
    endfunction

    always_comb begin
        st_nxt      = st_r;
        idx_nxt     = idx_r;
        kind_nxt    = kind_r;
        test_nxt    = test_r;
        opa_nxt     = opa_r;
        sp_nxt      = sp_r;
        x_nxt       = x_r;
        a_nxt       = a_r;
        b_nxt       = b_r;
        ccr_nxt     = ccr_r;
        vbase_nxt   = vbase_r;
        off_nxt     = off_r;
        vhi_nxt     = vhi_r;
        rhi_nxt     = rhi_r;
        pc_out_nxt  = pc_out_r;
        sp_out_nxt  = sp_out_r;
        x_out_nxt   = x_out_r;
        a_out_nxt   = a_out_r;
        b_out_nxt   = b_out_r;
        ccr_out_nxt = ccr_out_r;
        done_nxt    = 1'b0;
        unique case (st_r)
            bus_seq_pkg::S_IDLE: begin
                if (op_start) begin
                    kind_nxt  = op_kind;
                    test_nxt  = branch_test;
                    opa_nxt   = op_addr;
                    sp_nxt    = sp_in;
                    x_nxt     = x_in;
                    a_nxt     = a_in;
                    b_nxt     = b_in;
                    ccr_nxt   = ccr_in;
                    vbase_nxt = bus_seq_pkg::VEC_TRAP_HI;
                    st_nxt    = bus_seq_pkg::S_FETCH;
                end
            end
            bus_seq_pkg::S_FETCH: begin
                off_nxt = rd_val;
                st_nxt  = bus_seq_pkg::S_DUMMY;
            end
            bus_seq_pkg::S_DUMMY: begin
                idx_nxt = 3'h0;
                if (kind_r == bus_seq_pkg::OP_BRANCH) begin
                    st_nxt = bus_seq_pkg::S_LAST;
                end else if (kind_r == bus_seq_pkg::OP_RETURN) begin
                    st_nxt = bus_seq_pkg::S_PULL;
                end else begin
                    st_nxt = bus_seq_pkg::S_PUSH;
                end
            end
            bus_seq_pkg::S_PUSH: begin
                if (kind_r == bus_seq_pkg::OP_BSR && idx_r == bus_seq_pkg::BSR_LAST) begin
                    st_nxt = bus_seq_pkg::S_LAST;
                end else if (idx_r == bus_seq_pkg::STACK_LAST) begin
                    idx_nxt = 3'h0;
                    st_nxt  = (kind_r == bus_seq_pkg::OP_TRAP) ? bus_seq_pkg::S_VEC :
                              bus_seq_pkg::S_WAIT;
                end else begin
                    idx_nxt = 3'(idx_r + 3'h1);
                end
            end
            bus_seq_pkg::S_PULL: begin
                case (idx_r)
                    3'h0:    ccr_out_nxt = rd_val;
                    3'h1:    b_out_nxt = rd_val;
                    3'h2:    a_out_nxt = rd_val;
                    3'h3:    x_out_nxt[15:8] = rd_val;
                    3'h4:    x_out_nxt[7:0] = rd_val;
                    3'h5:    rhi_nxt = rd_val;
                    default: rhi_nxt = rhi_r;
                endcase
                if (idx_r == bus_seq_pkg::STACK_LAST) begin
                    st_nxt = bus_seq_pkg::S_LAST;
                end else begin
                    idx_nxt = 3'(idx_r + 3'h1);
                end
            end
            bus_seq_pkg::S_WAIT: begin
                if (irq_pending) begin
                    vbase_nxt = irq_vector;
                    idx_nxt   = 3'h0;
                    st_nxt    = bus_seq_pkg::S_VEC;
                end
            end
            bus_seq_pkg::S_VEC: begin
                if (idx_r == 3'h0) begin
                    vhi_nxt = rd_val;
                    idx_nxt = 3'h1;
                end else begin
                    st_nxt = bus_seq_pkg::S_LAST;
                end
            end
            bus_seq_pkg::S_LAST: begin
                st_nxt = bus_seq_pkg::S_IDLE;
            end
            default: begin
                st_nxt = bus_seq_pkg::S_IDLE;
            end
        endcase
        if (!run_ok) begin
            st_nxt  = bus_seq_pkg::S_IDLE;
            idx_nxt = 3'h0;
        end

        // Bus levels for the cycle that st_nxt presents
        addr_nxt = bus_seq_pkg::VEC_DUMMY;
        rw_nxt   = 1'b1;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        dout_nxt = dout_r;
        unique case (st_nxt)
            bus_seq_pkg::S_FETCH: begin
                addr_nxt = 16'(opa_nxt + bus_seq_pkg::ONE_BYTE);
                rd_n_nxt = 1'b0;
            end
            bus_seq_pkg::S_PUSH: begin
                addr_nxt = 16'(sp_nxt - {13'h0, idx_nxt});
                rw_nxt   = 1'b0;
                wr_n_nxt = 1'b0;
                dout_nxt = push_sel(idx_nxt, ret_addr, x_nxt, a_nxt, b_nxt, ccr_nxt);
            end
            bus_seq_pkg::S_PULL: begin
                addr_nxt = 16'(sp_nxt + bus_seq_pkg::ONE_BYTE + {13'h0, idx_nxt});
                rd_n_nxt = 1'b0;
            end
            bus_seq_pkg::S_VEC: begin
                addr_nxt = 16'(vbase_nxt + {13'h0, idx_nxt});
                rd_n_nxt = 1'b0;
            end
            bus_seq_pkg::S_LAST: begin
                rd_n_nxt = 1'b0;
                done_nxt = 1'b1;
                if (kind_r == bus_seq_pkg::OP_BRANCH) begin
                    addr_nxt   = test_r ? br_tgt : 16'(opa_r + bus_seq_pkg::TWO_BYTES);
                    sp_out_nxt = sp_r;
                end else if (kind_r == bus_seq_pkg::OP_BSR) begin
                    addr_nxt   = br_tgt;
                    sp_out_nxt = 16'(sp_r - bus_seq_pkg::TWO_BYTES);
                end else if (kind_r == bus_seq_pkg::OP_RETURN) begin
                    addr_nxt   = {rhi_r, rd_val};
                    sp_out_nxt = 16'(sp_r + bus_seq_pkg::STACK_DELTA);
                end else begin
                    addr_nxt   = {vhi_r, rd_val};
                    sp_out_nxt = 16'(sp_r - bus_seq_pkg::STACK_DELTA);
                end
                pc_out_nxt = addr_nxt;
            end
            default: begin
                addr_nxt = bus_seq_pkg::VEC_DUMMY;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r      <= bus_seq_pkg::S_IDLE;
            idx_r     <= 3'h0;
            kind_r    <= bus_seq_pkg::OP_BRANCH;
            test_r    <= 1'b0;
            opa_r     <= bus_seq_pkg::WORD_RST;
            sp_r      <= bus_seq_pkg::WORD_RST;
            x_r       <= bus_seq_pkg::WORD_RST;
            a_r       <= bus_seq_pkg::BYTE_RST;
            b_r       <= bus_seq_pkg::BYTE_RST;
            ccr_r     <= bus_seq_pkg::BYTE_RST;
            vbase_r   <= bus_seq_pkg::VEC_TRAP_HI;
            off_r     <= bus_seq_pkg::BYTE_RST;
            vhi_r     <= bus_seq_pkg::BYTE_RST;
            rhi_r     <= bus_seq_pkg::BYTE_RST;
            addr_r    <= bus_seq_pkg::ADDR_RST;
            rw_r      <= 1'b1;
            rd_n_r    <= 1'b1;
            wr_n_r    <= 1'b1;
            dout_r    <= bus_seq_pkg::BYTE_RST;
            done_r    <= 1'b0;
            pc_out_r  <= bus_seq_pkg::WORD_RST;
            sp_out_r  <= bus_seq_pkg::WORD_RST;
            x_out_r   <= bus_seq_pkg::WORD_RST;
            a_out_r   <= bus_seq_pkg::BYTE_RST;
            b_out_r   <= bus_seq_pkg::BYTE_RST;
            ccr_out_r <= bus_seq_pkg::BYTE_RST;
        end else begin
            st_r      <= st_nxt;
            idx_r     <= idx_nxt;
            kind_r    <= kind_nxt;
            test_r    <= test_nxt;
            opa_r     <= opa_nxt;
            sp_r      <= sp_nxt;
            x_r       <= x_nxt;
            a_r       <= a_nxt;
            b_r       <= b_nxt;
            ccr_r     <= ccr_nxt;
            vbase_r   <= vbase_nxt;
            off_r     <= off_nxt;
            vhi_r     <= vhi_nxt;
            rhi_r     <= rhi_nxt;
            addr_r    <= addr_nxt;
            rw_r      <= rw_nxt;
            rd_n_r    <= rd_n_nxt;
            wr_n_r    <= wr_n_nxt;
            dout_r    <= dout_nxt;
            done_r    <= done_nxt;
            pc_out_r  <= pc_out_nxt;
            sp_out_r  <= sp_out_nxt;
            x_out_r   <= x_out_nxt;
            a_out_r   <= a_out_nxt;
            b_out_r   <= b_out_nxt;
            ccr_out_r <= ccr_out_nxt;
        end
    end

    property p_wait_seq;
        @(posedge ref_clk) disable iff (rst)
        (st_r == bus_seq_pkg::S_IDLE && op_start && op_kind == bus_seq_pkg::OP_IDLE_IRQ && run_ok)
        |=> (st_r == bus_seq_pkg::S_FETCH) ##1 (addr_r == bus_seq_pkg::VEC_DUMMY)
            ##1 (!wr_n_r)[*7] ##1 (st_r == bus_seq_pkg::S_WAIT);
    endproperty
    a_wait_seq: assert property (p_wait_seq) else $error("wait sequence wrong");

    property p_return_len;
        @(posedge ref_clk) disable iff (rst || !run_ok)
        (st_r == bus_seq_pkg::S_IDLE && op_start && op_kind == bus_seq_pkg::OP_RETURN)
        |-> ##3 (addr_r == 16'(sp_r + bus_seq_pkg::ONE_BYTE)) ##7 (done_r && !rd_n_r);
    endproperty
    a_return_len: assert property (p_return_len) else $error("return length wrong");

    property p_trap_vec;
        @(posedge ref_clk) disable iff (rst || !run_ok)
        (st_r == bus_seq_pkg::S_IDLE && op_start && op_kind == bus_seq_pkg::OP_TRAP)
        |-> ##10 (addr_r == bus_seq_pkg::VEC_TRAP_HI) ##1 (addr_r == bus_seq_pkg::VEC_TRAP_LO)
            ##1 done_r;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

    property p_dummy;
        @(posedge ref_clk) disable iff (rst)
        (st_r == bus_seq_pkg::S_DUMMY) |->
        (addr_r == bus_seq_pkg::VEC_DUMMY && rd_n_r && wr_n_r && rw_r);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");

    property p_strobes;
        @(posedge ref_clk) disable iff (rst)
        (rw_r |-> wr_n_r) and (!rw_r |-> (!wr_n_r && rd_n_r));
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobe level wrong");

    property p_branch;
        @(posedge ref_clk) disable iff (rst || !run_ok)
        (st_r == bus_seq_pkg::S_IDLE && op_start && op_kind == bus_seq_pkg::OP_BRANCH && !branch_test)
        |-> ##3 (done_r && addr_r == 16'(opa_r + bus_seq_pkg::TWO_BYTES)) ##1 !busy;
    endproperty
    a_branch: assert property (p_branch) else $error("branch cycle wrong");

    property p_bsr;
        @(posedge ref_clk) disable iff (rst || !run_ok)
        (st_r == bus_seq_pkg::S_IDLE && op_start && op_kind == bus_seq_pkg::OP_BSR)
        |-> ##3 (addr_r == sp_r && !wr_n_r) ##1 (addr_r == 16'(sp_r - bus_seq_pkg::ONE_BYTE))
            ##1 (done_r && sp_out_r == 16'(sp_r - bus_seq_pkg::TWO_BYTES));
    endproperty
    a_bsr: assert property (p_bsr) else $error("subroutine push wrong");

    property p_wo_read;
        @(posedge ref_clk) disable iff (rst)
        (st_r == bus_seq_pkg::S_FETCH && wo_hit && run_ok) |=> (off_r == bus_seq_pkg::WO_READ);
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only read not ff");

    property p_clear;
        @(posedge ref_clk) disable iff (rst)
        (!run_ok) |=> (st_r == bus_seq_pkg::S_IDLE && !done_r);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not idle");

    property p_sp_return;
        @(posedge ref_clk) disable iff (rst)
        (done_r && kind_r == bus_seq_pkg::OP_RETURN) |->
        (sp_out_r == 16'(sp_r + bus_seq_pkg::STACK_DELTA));
    endproperty
    a_sp_return: assert property (p_sp_return) else $error("return sp wrong");

endmodule

/* testbench/bus_mem_model.sv */
// Purpose: Memory and peripheral model on the far side of the sequencer bus
// Assumes: Reads are answered in the same cycle the address is presented
// Notes:   One address is a write-only register; idle cycles show no stale byte
`timescale 1ns/100ps
module bus_mem_model #(
    parameter logic [15:0] WO_ADDR = 16'h0012
) (
    // Clock
    input  wire logic        ref_clk,
    // Bus from the sequencer
    input  wire logic [15:0] addr_r,
    input  wire logic        rd_n_r,
    // Answer
    output logic [7:0]       din,
    output logic             wo_hit
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] rd_val;

    // Stored byte is a pattern of the address; the write-only place holds 48, not ff
    assign rd_val = addr_r[15:8] ^ addr_r[7:0] ^ 8'h5a;
    // Unread cycles show the inverse of the last byte, so the pattern keeps moving
    assign din    = rd_n_r ? ~last_r : rd_val;
    assign wo_hit = !rd_n_r && (addr_r == WO_ADDR);

    always @(posedge ref_clk) begin
        last_r <= din;
    end
endmodule

/* testbench/cpu_bus_cycle_sequencer_tb.sv */
// Purpose: Self-checking bench for the bus-cycle sequencer
// Assumes: Inputs change on the falling edge; random values from a fixed seed
// Notes:   Expected bus cycles are queued per instruction, then compared cycle by cycle
`timescale 1ns/100ps
module cpu_bus_cycle_sequencer_tb;
    localparam logic [15:0] WO_ADDR = 16'h0012;
    typedef struct packed {
        logic [15:0] a;
        logic [1:0]  k;
        logic [7:0]  d;
    } cyc_t;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        power_on_clear_input_n = 1'b0;
    logic        op_start = 1'b0;
    logic        branch_test = 1'b0;
    logic        irq_pending = 1'b0;
    logic [2:0]  op_kind = 3'h0;
    logic [15:0] op_addr = 16'h0000, sp_in = 16'h0000, x_in = 16'h0000, irq_vector = 16'h0000;
    logic [7:0]  a_in = 8'h00, b_in = 8'h00, ccr_in = 8'h00;
    logic [7:0]  din, dout_r, a_out_r, b_out_r, ccr_out_r, off;
    logic [15:0] addr_r, pc_out_r, sp_out_r, x_out_r, ret;
    logic        busy, rw_r, rd_n_r, wr_n_r, wo_hit, done_r, seen;
    logic [31:0] rs = 32'd72;
    int          error_cnt = 0, comparisons = 0, cycles = 0, n, t, k;
    cyc_t        exp_q[$];

    always #4 ref_clk = ~ref_clk;

    bus_cycle_seq dut (
        .ref_clk(ref_clk), .rst(rst), .power_on_clear_input_n(power_on_clear_input_n),
        .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .branch_test(branch_test),
        .sp_in(sp_in), .x_in(x_in), .a_in(a_in), .b_in(b_in), .ccr_in(ccr_in),
        .irq_pending(irq_pending), .irq_vector(irq_vector), .busy(busy),
        .addr_r(addr_r), .rw_r(rw_r), .rd_n_r(rd_n_r), .wr_n_r(wr_n_r), .dout_r(dout_r),
        .din(din), .wo_hit(wo_hit), .done_r(done_r), .pc_out_r(pc_out_r),
        .sp_out_r(sp_out_r), .x_out_r(x_out_r), .a_out_r(a_out_r), .b_out_r(b_out_r),
        .ccr_out_r(ccr_out_r)
    );
    bus_mem_model #(.WO_ADDR(WO_ADDR)) mem (
        .ref_clk(ref_clk), .addr_r(addr_r), .rd_n_r(rd_n_r), .din(din), .wo_hit(wo_hit)
    );

    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // Byte the CPU should see at an address
    function automatic logic [7:0] mval(input logic [15:0] a);
        return (a == WO_ADDR) ? 8'hff : (a[15:8] ^ a[7:0] ^ 8'h5a);
    endfunction

    task automatic fail(input string msg);
        error_cnt++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
            fail(msg);
    endtask

    // Kind 0 read, 1 write, 2 dummy
    task automatic cmp_bus(input cyc_t e, input logic dn);
        logic [2:0] st;
        st = (e.k == 2'd0) ? 3'b101 : (e.k == 2'd1) ? 3'b010 : 3'b111;
        comparisons++;
        if ({addr_r, rw_r, rd_n_r, wr_n_r, done_r} !== {e.a, st, dn}
            || (e.k == 2'd1 && dout_r !== e.d))
            fail("bus cycle differs");
    endtask

    task automatic add(input logic [15:0] a, input logic [1:0] kd, input logic [7:0] d);
        exp_q.push_back('{a, kd, d});
    endtask

    task automatic pre();
        exp_q.delete();
        add(op_addr + 16'h0001, 2'd0, 8'h00);
        add(16'hffff, 2'd2, 8'h00);
    endtask

    task automatic push7(input logic [15:0] s, input logic [15:0] r);
        logic [7:0] v[7];
        v = '{r[7:0], r[15:8], x_in[7:0], x_in[15:8], a_in, b_in, ccr_in};
        for (int i = 0; i < 7; i++)
            add(s - 16'(i), 2'd1, v[i]);
    endtask

    task automatic tail3(input logic [15:0] a);
        add(a, 2'd0, 8'h00);
        add(a + 16'h0001, 2'd0, 8'h00);
        add({mval(a), mval(a + 16'h0001)}, 2'd0, 8'h00);
    endtask

    // Start one instruction and walk its queued cycles; a second start mid-op is ignored
    task automatic run(input logic [2:0] kind, input int wait_at);
        int i;
        @(negedge ref_clk);
        op_kind = kind;
        op_start = 1'b1;
        @(negedge ref_clk);
        n = 0;
        while (addr_r !== exp_q[0].a && n < 3) begin
            @(negedge ref_clk);
            n++;
        end
        for (i = 0; i < exp_q.size(); i++) begin
            if (i > 0)
                @(negedge ref_clk);
            if (i == wait_at) begin
                repeat (3) begin
                    cmp_bus('{16'hffff, 2'd2, 8'h00}, 1'b0);
                    @(negedge ref_clk);
                end
                irq_pending = 1'b1;
                n = 0;
                while (addr_r !== exp_q[i].a && n < 3) begin
                    @(negedge ref_clk);
                    n++;
                end
            end
            op_start = (i == 1);
            op_kind = 3'(rnd() % 5);
            cmp_bus(exp_q[i], i == exp_q.size() - 1);
        end
        irq_pending = 1'b0;
        cmp_val(pc_out_r, exp_q[exp_q.size() - 1].a, "final fetch address");
        $display("op kind %0d finished", kind);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail("timeout");
            complete_run();
        end
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        cmp_bus('{16'hffff, 2'd2, 8'h00}, 1'b0);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        power_on_clear_input_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        for (t = 0; t < 5; t++) begin
            // First pass fetches the branch offset from the write-only register
            op_addr = (t == 0) ? WO_ADDR - 16'h0001 : 16'(rnd());
            sp_in = 16'(rnd());
            x_in = 16'(rnd());
            {a_in, b_in, ccr_in} = 24'(rnd());
            irq_vector = 16'(rnd());
            for (k = 0; k < 2; k++) begin
                branch_test = k[0];
                pre();
                off = mval(op_addr + 16'h0001);
                ret = op_addr + 16'h0002;
                add(k[0] ? ret + {{8{off[7]}}, off} : ret, 2'd0, 8'h00);
                run(bus_seq_pkg::OP_BRANCH, -1);
            end
            pre();
            add(sp_in, 2'd1, ret[7:0]);
            add(sp_in - 16'h0001, 2'd1, ret[15:8]);
            add(ret + {{8{off[7]}}, off}, 2'd0, 8'h00);
            run(bus_seq_pkg::OP_BSR, -1);
            cmp_val(sp_out_r, sp_in - 16'h0002, "subroutine stack pointer");
            pre();
            push7(sp_in, op_addr + 16'h0001);
            tail3(16'hfffa);
            run(bus_seq_pkg::OP_TRAP, -1);
            cmp_val(sp_out_r, sp_in - 16'h0007, "trap stack pointer");
            // Three idle cycles at ffff are checked before the interrupt is raised
            pre();
            push7(sp_in, op_addr + 16'h0001);
            tail3(irq_vector);
            run(bus_seq_pkg::OP_IDLE_IRQ, 9);
            cmp_val(sp_out_r, sp_in - 16'h0007, "wait stack pointer");
            // First pass puts the write-only register under accumulator B
            if (t == 0)
                sp_in = WO_ADDR - 16'h0002;
            pre();
            for (k = 1; k < 8; k++)
                add(sp_in + 16'(k), 2'd0, 8'h00);
            add({mval(sp_in + 16'h0006), mval(sp_in + 16'h0007)}, 2'd0, 8'h00);
            run(bus_seq_pkg::OP_RETURN, -1);
            cmp_val(x_out_r, {mval(sp_in + 16'h0004), mval(sp_in + 16'h0005)}, "x");
            cmp_val({a_out_r, b_out_r}, {mval(sp_in + 16'h0003), mval(sp_in + 16'h0002)}, "ab");
            cmp_val({8'h00, ccr_out_r}, {8'h00, mval(sp_in + 16'h0001)}, "ccr");
            cmp_val(sp_out_r, sp_in + 16'h0007, "return stack pointer");
        end
        // Clear pin dropped mid-trap aborts it; a start while it is low is ignored
        @(negedge ref_clk);
        op_kind = bus_seq_pkg::OP_TRAP;
        op_start = 1'b1;
        @(negedge ref_clk);
        op_start = 1'b0;
        repeat (3) @(negedge ref_clk);
        power_on_clear_input_n = 1'b0;
        seen = 1'b0;
        for (k = 0; k < 12; k++) begin
            @(negedge ref_clk);
            seen = seen | done_r;
            op_start = (k == 5);
        end
        cmp_val({14'h0000, seen, busy}, 16'h0000, "clear did not hold idle");
        power_on_clear_input_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        $display("clear test finished");
        complete_run();
    end
endmodule
